/* pkg/sas_pkg.sv */
// constants and types shared by the converter sequencer
package sas_pkg;
    // ------------------------------------------------------------
    // register map (index, byte address is four times the index)
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [9:0] CTRL_IDX = 10'h0c5;
    localparam logic [9:0] RES_IDX = 10'h0c6;
    localparam logic [9:0] AUX_IDX = 10'h0c7;
    localparam int CB_RES1 = 7;
    localparam int CB_RES0 = 6;
    localparam int CB_EXT = 5;
    localparam int CB_DONE = 4;
    localparam int CB_START = 3;
    localparam int CB_CH_HI = 2;
    localparam int AUX_B8 = 7;
    localparam int AUX_IDLE = 6;
    localparam int HT_ACT = 1;
    // ------------------------------------------------------------
    // timing in machine cycles
    // ------------------------------------------------------------
    localparam logic [3:0] MC_DIV = 4'hc;
    localparam logic [5:0] INIT_CYC = 6'h02;
    localparam logic [2:0] SAMP10 = 3'h7;
    localparam logic [2:0] SAMP8 = 3'h5;
    localparam logic [2:0] BIT10 = 3'h3;
    localparam logic [2:0] BIT8 = 3'h1;
    localparam logic [5:0] TOT10 = 6'h32;
    localparam logic [5:0] TOT8 = 6'h18;
    localparam logic [3:0] MSB_IDX = 4'h9;
    localparam logic [3:0] LSB8_IDX = 4'h2;
    localparam logic [9:0] MSB_ONE = 10'h200;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT = 5'b00010,
        ST_INIT = 5'b00100,
        ST_SAMP = 5'b01000,
        ST_BITS = 5'b10000
    } sas_seq_t;
    typedef struct packed {
        logic hsel;
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } sas_ahb_in_t;
    typedef struct packed {
        logic [2:0] chan;
        logic [9:0] trial;
        logic sample;
        logic powered;
    } sas_ana_t;
    typedef struct packed {
        sas_seq_t seq;
        logic cmd;
        logic busy;
        logic done;
        logic ext_en;
        logic [2:0] chan;
        logic eight;
        logic idle_act;
        logic [9:0] sar;
        logic [3:0] bp;
        logic [5:0] tot;
        logic [2:0] sub;
        logic [7:0] res_hi;
        logic [1:0] res_lo;
        logic pin_prev;
        logic smp;
        logic wr_pend;
        logic [9:0] wr_idx;
        logic [7:0] rdata;
    } sas_regs_t;
    localparam sas_regs_t REGS_RST = '{seq: ST_IDLE, default: '0};
endpackage : sas_pkg

/* hw/sas_sync.sv */
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sas_sync (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // pin
    input wire logic din,
    output logic dout
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } sas_sync_t;
    sas_sync_t r;
    sas_sync_t next_r;
    always_comb begin
        next_r = r;
        next_r.s1 = din;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // only a level seen by both later stages counts
        if (r.s2 == r.s3) begin
            next_r.lvl = r.s3;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end
    assign dout = r.lvl;
endmodule : sas_sync

/* hw/sas_mcyc.sv */
// machine-cycle strobe from the core clock
`timescale 1ns/1ps
module sas_mcyc (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic srst,
    // strobe
    output logic stb
);
    import sas_pkg::*;
    typedef struct packed {
        logic [3:0] cnt;
    } sas_mc_t;
    sas_mc_t r;
    sas_mc_t next_r;
    assign stb = (r.cnt == MC_DIV - 4'h1);
    always_comb begin
        next_r = r;
        next_r.cnt = (stb || srst) ? 4'h0 : r.cnt + 4'h1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end
endmodule : sas_mcyc

/* hw/sas_adc.sv */
// successive-approximation converter sequencer with ahb-lite registers
// Function
// - ten-bit conversion lasts exactly 50 machine cycles
// - eight-bit select: 24 cycles, result high byte
// - idle-active select keeps converter running in idle
// - external enable adds pin rising edge start
// - pin edge seen at cycle end, starts next
// - software start begins in following machine cycle
// - start is command flop plus status flag
// - two init cycles, status after first one
// - sample selected channel eight machine cycles, six in eight-bit
// - msb first trial, keep bit if greater
// - four machine cycles per bit decision, two in eight-bit
// - result high byte plus control bits 7:6
// - done set, status cleared at 50/24
// - channel field selects analog input 0..7
// - channel writes only when done, status low
// - starts during conversion ignored, no disturbance
// - no start while done or status set
// - idle or power-down aborts running conversion
// - done flag set by hardware, software clears
// - status high while busy, cleared in the cycle done sets
// - clearing done with start write may start
`timescale 1ns/1ps
module sas_adc (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic srst,
    // ahb-lite slave
    input sas_pkg::sas_ahb_in_t bus,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // power state of the core
    input wire logic cpu_idle,
    input wire logic power_down,
    // analog side
    input wire logic ext_start_pin,
    input wire logic comp_gt,
    output sas_pkg::sas_ana_t ana,
    // completion request
    output logic done_irq
);
    import sas_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    sas_regs_t r;
    sas_regs_t next_r;
    logic stb;
    logic pin_s;
    logic cmp_s;
    logic acc_ok;
    logic [7:0] wd;
    logic clr_done;
    logic sw_req;
    logic pin_req;
    logic can_start;
    logic pwr;
    logic fin;
    logic [9:0] fin_sar;
    logic [2:0] samp_last;
    logic [2:0] bit_last;
    logic [3:0] low_bp;

    function automatic logic [7:0] rd_byte(sas_regs_t s, logic [9:0] idx);
        logic [7:0] v;
        v = 8'h00;
        if (idx == CTRL_IDX) begin
            v[CB_RES1] = s.res_lo[1];
            v[CB_RES0] = s.res_lo[0];
            v[CB_EXT] = s.ext_en;
            v[CB_DONE] = s.done;
            v[CB_START] = s.busy;
            v[CB_CH_HI:0] = s.chan;
        end else if (idx == RES_IDX) begin
            v = s.res_hi;
        end else if (idx == AUX_IDX) begin
            v[AUX_B8] = s.eight;
            v[AUX_IDLE] = s.idle_act;
        end
        return v;
    endfunction : rd_byte

    // ------------------------------------------------------------
    // pacing and pin capture
    // ------------------------------------------------------------
    sas_mcyc u_mcyc (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .srst(srst),
        .stb(stb)
    );
    sas_sync u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .din(ext_start_pin),
        .dout(pin_s)
    );
    // comparator is analog, so it is treated as asynchronous
    sas_sync u_cmp_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .din(comp_gt),
        .dout(cmp_s)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        acc_ok = bus.hsel && bus.htrans[HT_ACT] && bus.hready;
        wd = bus.hwdata[7:0];
        clr_done = 1'b0;
        sw_req = 1'b0;
        fin = 1'b0;
        pwr = !power_down && !(cpu_idle && !r.idle_act);
        samp_last = r.eight ? SAMP8 : SAMP10;
        bit_last = r.eight ? BIT8 : BIT10;
        low_bp = r.eight ? LSB8_IDX : 4'h0;
        fin_sar = r.sar;
        if (!cmp_s) begin
            fin_sar[r.bp] = 1'b0;
        end
        // register writes land in the data phase
        if (r.wr_pend && r.wr_idx == CTRL_IDX) begin
            next_r.ext_en = wd[CB_EXT];
            clr_done = !wd[CB_DONE];
            sw_req = wd[CB_START];
            if (!r.done && !r.busy) begin
                next_r.chan = wd[CB_CH_HI:0];
            end
        end
        // mode bits frozen while a conversion runs
        if (r.wr_pend && r.wr_idx == AUX_IDX && !r.cmd) begin
            next_r.eight = wd[AUX_B8];
            next_r.idle_act = wd[AUX_IDLE];
        end
        // clearing done in the same write lets the start through
        can_start = pwr && !r.cmd && !r.busy && !(r.done && !clr_done);
        pin_req = stb && r.ext_en && !r.pin_prev && pin_s;
        if (stb) begin
            next_r.pin_prev = pin_s;
        end
        unique case (r.seq)
            ST_IDLE: begin
                if (can_start && pin_req) begin
                    next_r.cmd = 1'b1;
                    next_r.tot = 6'h00;
                    next_r.seq = ST_INIT;
                end else if (can_start && sw_req) begin
                    next_r.cmd = 1'b1;
                    next_r.tot = 6'h00;
                    next_r.seq = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (stb) begin
                    next_r.seq = ST_INIT;
                end
            end
            ST_INIT: begin
                if (stb) begin
                    next_r.tot = r.tot + 6'h01;
                    if (r.tot == 6'h00) begin
                        next_r.busy = 1'b1;
                    end
                    if (r.tot == INIT_CYC - 6'h01) begin
                        next_r.seq = ST_SAMP;
                        next_r.smp = 1'b1;
                        next_r.sub = 3'h0;
                    end
                end
            end
            ST_SAMP: begin
                if (stb) begin
                    next_r.tot = r.tot + 6'h01;
                    next_r.sub = r.sub + 3'h1;
                    if (r.sub == samp_last) begin
                        next_r.smp = 1'b0;
                        next_r.seq = ST_BITS;
                        next_r.sar = MSB_ONE;
                        next_r.bp = MSB_IDX;
                        next_r.sub = 3'h0;
                    end
                end
            end
            ST_BITS: begin
                if (stb) begin
                    next_r.tot = r.tot + 6'h01;
                    next_r.sub = r.sub + 3'h1;
                    if (r.sub == bit_last) begin
                        next_r.sub = 3'h0;
                        next_r.sar = fin_sar;
                        if (r.bp == low_bp) begin
                            fin = 1'b1;
                        end else begin
                            next_r.bp = r.bp - 4'h1;
                            next_r.sar[r.bp - 4'h1] = 1'b1;
                        end
                    end
                end
            end
        endcase
        if (fin) begin
            next_r.seq = ST_IDLE;
            next_r.cmd = 1'b0;
            next_r.busy = 1'b0;
            next_r.res_hi = fin_sar[9:2];
            next_r.res_lo = r.eight ? 2'h0 : fin_sar[1:0];
        end
        // hardware set wins over a software clear
        next_r.done = fin || (r.done && !clr_done);
        // a completed result survives; a running one does not
        if (!pwr && r.cmd) begin
            next_r.seq = ST_IDLE;
            next_r.cmd = 1'b0;
            next_r.busy = 1'b0;
            next_r.smp = 1'b0;
        end
        next_r.wr_pend = acc_ok && bus.hwrite;
        next_r.wr_idx = bus.haddr[ADDR_W-1:2];
        // read data taken after any write finishing this cycle
        if (acc_ok && !bus.hwrite) begin
            next_r.rdata = rd_byte(next_r, bus.haddr[ADDR_W-1:2]);
        end
        if (srst) begin
            next_r = REGS_RST;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= REGS_RST;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // a frozen block must stall the bus, not drop a write
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = {24'h000000, r.rdata};
    assign ana.chan = r.chan;
    assign ana.trial = r.sar;
    assign ana.sample = r.smp;
    assign ana.powered = pwr;
    assign done_irq = r.done;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn || srst);

    property p_ten_len;
        ($rose(r.done) && !r.eight) |-> $past(r.tot) == TOT10 - 6'h01;
    endproperty
    a_ten_len: assert property (p_ten_len) else $error("ten-bit length wrong");
    property p_eight_len;
        ($rose(r.done) && r.eight) |-> ($past(r.tot) == TOT8 - 6'h01) && (r.res_lo == 2'h0);
    endproperty
    a_eight_len: assert property (p_eight_len) else $error("eight-bit length wrong");
    property p_status_rise;
        $rose(r.busy) |-> $past(r.seq) == ST_INIT && $past(r.tot) == 6'h00;
    endproperty
    a_status_rise: assert property (p_status_rise) else $error("status rose at wrong cycle");
    property p_sample_start;
        $rose(r.smp) |-> $past(r.tot) == INIT_CYC - 6'h01 && $past(stb);
    endproperty
    a_sample_start: assert property (p_sample_start) else $error("sampling began off time");
    property p_msb_first;
        (r.seq == ST_BITS && $past(r.seq) == ST_SAMP) |-> r.sar == MSB_ONE && r.bp == MSB_IDX;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("approximation did not start at msb");
    property p_result;
        ($rose(r.done) && !r.eight) |-> {r.res_hi, r.res_lo} == $past(fin_sar);
    endproperty
    a_result: assert property (p_result) else $error("result not placed");
    property p_done_status;
        $rose(r.done) |-> !r.busy && !r.cmd && $past(fin);
    endproperty
    a_done_status: assert property (p_done_status) else $error("done without completion");
    property p_chan_hold;
        // a reset edge may clear the channel; its sampled strobe masks that attempt
        (r.busy || r.done) && !srst |=> $stable(r.chan);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel changed while blocked");
    property p_no_start;
        $rose(r.cmd) |-> !$past(r.done) || $past(clr_done);
    endproperty
    a_no_start: assert property (p_no_start) else $error("start while done set");
    property p_pin_start;
        ($rose(r.cmd) && r.seq == ST_INIT) |-> $past(r.ext_en) && $past(stb);
    endproperty
    a_pin_start: assert property (p_pin_start) else $error("pin start without enable");
    property p_abort;
        (!pwr && r.cmd && ce) |=> !r.cmd && !r.busy && r.seq == ST_IDLE;
    endproperty
    a_abort: assert property (p_abort) else $error("conversion not aborted");
    property p_ignore;
        (r.seq == ST_BITS && !stb && pwr && ce && !srst) |=> r.seq == ST_BITS && $stable(r.sar);
    endproperty
    a_ignore: assert property (p_ignore) else $error("running conversion disturbed");

    c_ten: cover property ($rose(r.done) && !r.eight);
    c_eight: cover property ($rose(r.done) && r.eight);
    c_pin: cover property ($rose(r.cmd) && r.seq == ST_INIT);
    c_abort: cover property (!pwr && r.cmd);
endmodule : sas_adc

/* tb/sas_partner.sv */
// behavioural comparator and analog inputs facing the sequencer
`timescale 1ns/1ps
module sas_partner
    import sas_pkg::*;
(
    // clock
    input wire logic hclk,
    // analog side
    input sas_pkg::sas_ana_t ana,
    output logic comp_gt
);
    // ------------------------------------------------------------
    // comparator
    // ------------------------------------------------------------
    logic tog = 1'b0;
    // unpowered comparator output is meaningless, so it wanders
    always @(posedge hclk) tog <= ~tog;
    function automatic logic [9:0] vin(input logic [2:0] ch);
        return {ch, 7'h2b} ^ 10'h0a5;
    endfunction : vin
    assign comp_gt = ana.powered ? (vin(ana.chan) > ana.trial) : tog;
endmodule : sas_partner

/* tb/tb_top.sv */
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top;
    import sas_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic srst = 1'b0;
    logic hsel = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic cpu_idle = 1'b0;
    logic power_down = 1'b0;
    logic pin = 1'b0;
    logic comp_gt;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic done_irq;
    sas_ana_t ana;
    sas_ahb_in_t bus;
    int num_errors = 0;
    int n_tests = 0;
    int smp_n = 0;
    int n;
    logic [7:0] rd;
    // rows: {eight-bit select, channel, expected code}; channel c sits at ((c ^ 1) << 7) + 0x0e
    // strict compare keeps a bit only below the input, so the code lands one step under it
    logic [13:0] rows [8] = '{14'h008d, 14'h240c, 14'h098d, 14'h2d0c, 14'h128d, 14'h360c, 14'h1b8d, 14'h3f0c};
    assign bus = '{hsel: hsel, htrans: htrans, haddr: haddr, hwrite: hwrite,
                   hsize: 3'h2, hwdata: hwdata, hready: hreadyout};
    sas_adc DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .srst(srst), .bus(bus), .hrdata(hrdata),
                 .hreadyout(hreadyout), .hresp(hresp), .cpu_idle(cpu_idle), .power_down(power_down),
                 .ext_start_pin(pin), .comp_gt(comp_gt), .ana(ana), .done_irq(done_irq));
    sas_partner P (.hclk(hclk), .ana(ana), .comp_gt(comp_gt));
    initial begin
        forever #5 hclk = ~hclk;
    end
    always @(negedge hclk) if (ana.sample === 1'b1) smp_n++;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [9:0] exp_sar(input logic [2:0] ch, input logic eight);
        logic [9:0] v;
        logic [9:0] r;
        logic [9:0] t;
        v = {ch, 7'h2b} ^ 10'h0a5;
        r = 10'h000;
        for (int b = 9; b >= (eight ? 2 : 0); b--) begin
            t = r | (10'h001 << b);
            if (v > t) r = t;
        end
        return r;
    endfunction : exp_sar
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // one single transfer; address held until hready, data until hready again
    task automatic ahb(input logic wr, input logic [9:0] idx, input logic [7:0] wd, output logic [7:0] rdv);
        int k;
        k = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= 32'({idx, 2'b00});
        hwrite <= wr;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 200);
        rdv = hrdata[7:0];
    endtask : ahb
    task automatic wait_done(output int cnt);
        cnt = 0;
        while (done_irq !== 1'b1 && cnt < 2000) begin
            @(negedge hclk);
            cnt++;
        end
    endtask : wait_done
    task automatic idle_n(input int c);
        repeat (c) @(posedge hclk);
    endtask : idle_n
    task automatic convert(input logic [2:0] ch, input logic eight, input logic [9:0] e);
        int base;
        base = eight ? 288 : 600;
        ahb(1'b1, AUX_IDX, {eight, 7'h0}, rd);
        ahb(1'b1, CTRL_IDX, {5'h0, ch}, rd);
        smp_n = 0;
        ahb(1'b1, CTRL_IDX, {5'h1, ch}, rd);
        wait_done(n);
        check("duration", 1, 32'(n >= base && n <= base + 14));
        check("sample span", eight ? 72 : 96, smp_n);
        check("channel", 32'(ch), 32'(ana.chan));
        ahb(1'b0, RES_IDX, 8'h00, rd);
        check("result high", 32'(e[9:2]), 32'(rd));
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("control", {24'h0, eight ? 2'b00 : e[1:0], 3'b010, ch}, 32'(rd));
        ahb(1'b1, CTRL_IDX, {5'h0, ch}, rd);
        idle_n(2);
        check("done cleared", 0, 32'(done_irq));
    endtask : convert
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        idle_n(40000);
        num_errors++;
        report_and_stop();
    end
    initial begin
        idle_n(3);
        hresetn <= 1'b1;
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("control reset", 0, 32'(rd));
        ahb(1'b1, RES_IDX, 8'hff, rd);
        ahb(1'b0, RES_IDX, 8'h00, rd);
        check("result read-only", 0, 32'(rd));
        ahb(1'b0, 10'h0c8, 8'h00, rd);
        check("unmapped", 0, 32'(rd));
        check("okay response", 0, 32'(hresp));
        ahb(1'b1, CTRL_IDX, 8'h10, rd);
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("done not settable", 0, 32'(rd[4]));
        $display("test reset done");
        for (int i = 0; i < 8; i++) convert(rows[i][12:10], rows[i][13], rows[i][9:0]);
        $display("test rows done");
        // last row left eight-bit mode on; the timing below is ten-bit
        ahb(1'b1, AUX_IDX, 8'h00, rd);
        // blocked starts and channel writes
        ahb(1'b1, CTRL_IDX, 8'h02, rd);
        ahb(1'b1, CTRL_IDX, 8'h0a, rd);
        idle_n(100);
        ahb(1'b1, CTRL_IDX, 8'h0d, rd);
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("busy status", 8'h0a, 32'(rd));
        wait_done(n);
        check("undisturbed", 1, 32'(n >= 495 && n <= 506));
        ahb(1'b0, RES_IDX, 8'h00, rd);
        check("undisturbed result", 32'(exp_sar(3'h2, 1'b0) >> 2), 32'(rd));
        ahb(1'b1, CTRL_IDX, 8'h1b, rd);
        idle_n(40);
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("blocked by done", 8'h12, 32'({2'b00, rd[5:0]}));
        ahb(1'b1, CTRL_IDX, 8'h0b, rd);
        idle_n(40);
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("clear with start", 8'h0a, 32'({2'b00, rd[5:0]}));
        wait_done(n);
        ahb(1'b1, CTRL_IDX, 8'h00, rd);
        $display("test blocking done");
        // pin start, disabled then enabled; pin low well over a machine cycle first
        pin <= 1'b1;
        idle_n(60);
        pin <= 1'b0;
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("pin ignored", 0, 32'(rd[3]));
        ahb(1'b1, CTRL_IDX, 8'h20, rd);
        idle_n(24);
        pin <= 1'b1;
        wait_done(n);
        check("pin start", 1, 32'(n >= 600 && n <= 630));
        pin <= 1'b0;
        ahb(1'b1, CTRL_IDX, 8'h00, rd);
        $display("test pin done");
        // idle and power-down behaviour
        ahb(1'b1, CTRL_IDX, 8'h08, rd);
        idle_n(100);
        cpu_idle <= 1'b1;
        idle_n(3);
        check("powered off", 0, 32'(ana.powered));
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("idle abort", 0, 32'(rd[4:3]));
        cpu_idle <= 1'b0;
        ahb(1'b1, AUX_IDX, 8'h40, rd);
        ahb(1'b1, CTRL_IDX, 8'h08, rd);
        cpu_idle <= 1'b1;
        wait_done(n);
        check("idle active", 1, 32'(n >= 600 && n <= 614));
        ahb(1'b1, AUX_IDX, 8'h00, rd);
        idle_n(5);
        ahb(1'b0, RES_IDX, 8'h00, rd);
        check("result kept", 32'(exp_sar(3'h0, 1'b0) >> 2), 32'(rd));
        check("done kept", 1, 32'(done_irq));
        cpu_idle <= 1'b0;
        ahb(1'b1, CTRL_IDX, 8'h00, rd);
        ahb(1'b1, CTRL_IDX, 8'h08, rd);
        idle_n(100);
        power_down <= 1'b1;
        idle_n(3);
        power_down <= 1'b0;
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("power-down abort", 0, 32'(rd[4:3]));
        $display("test power done");
        // synchronous reset in mid-conversion
        ahb(1'b1, CTRL_IDX, 8'h0f, rd);
        idle_n(200);
        srst <= 1'b1;
        idle_n(1);
        srst <= 1'b0;
        ahb(1'b0, CTRL_IDX, 8'h00, rd);
        check("sync reset", 0, 32'(rd));
        idle_n(700);
        check("no late done", 0, 32'(done_irq));
        $display("test sync reset done");
        // clock enable low freezes the sequence for 100 clocks and stalls the bus
        ahb(1'b1, CTRL_IDX, 8'h08, rd);
        idle_n(50);
        ce <= 1'b0;
        idle_n(50);
        check("bus stalled", 0, 32'(hreadyout));
        idle_n(50);
        ce <= 1'b1;
        wait_done(n);
        check("frozen length", 1, 32'(n >= 551 && n <= 562));
        $display("test clock enable done");
        report_and_stop();
    end
endmodule : tb_top
